// File: design/console_ctrl.sv
// Design decisions made here: the address map and the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module console_ctrl (
  input  wire  logic                             CLK,            // 125 MHz
  input  wire  logic                             SRST,           // sync reset
  input  wire  logic [console_pkg::AXI_AW-1:0]   AWADDR,         // write addr
  input  wire  logic                             AWVALID,        // write addr valid
  output logic                                   AWREADY,        // write addr ready
  input  wire  logic [31:0]                      WDATA,          // write data
  input  wire  logic [3:0]                       WSTRB,          // byte strobes
  input  wire  logic                             WVALID,         // write data valid
  output logic                                   WREADY,         // write data ready
  output logic [1:0]                             BRESP,          // write response
  output logic                                   BVALID,         // response valid
  input  wire  logic                             BREADY,         // response ready
  input  wire  logic [console_pkg::AXI_AW-1:0]   ARADDR,         // read addr
  input  wire  logic                             ARVALID,        // read addr valid
  output logic                                   ARREADY,        // read addr ready
  output logic [31:0]                            RDATA,          // read data
  output logic [1:0]                             RRESP,          // read response
  output logic                                   RVALID,         // read valid
  input  wire  logic                             RREADY,         // read ready
  input  wire  logic [console_pkg::N_BTN-1:0]    PB,             // pushbuttons
  input  wire  logic                             KEY_ILK,        // interlock key
  input  wire  logic                             DISABLE_SW,     // interface disable
  input  wire  logic [1:0]                       CE_SEL_SW,      // unit select
  input  wire  logic [2:0]                       MS_SEL_SW,      // storage select
  input  wire  logic [3:0]                       CHAN_SW,        // load channel
  input  wire  logic [7:0]                       UNIT_SW,        // load unit addr
  input  wire  logic [31:0]                      DATA_KEYS,      // data keys
  input  wire  logic [23:0]                      ADDR_KEYS,      // address keys
  input  wire  logic [5:0]                       SENSE_SW,       // sense switches
  input  wire  logic [console_pkg::N_RCU-1:0]    RCU_PWR_SW,     // reconfig power
  input  wire  logic [console_pkg::N_RCU-1:0]    RCU_IF_SW,      // reconfig iface
  input  wire  logic [2*console_pkg::N_RCU-1:0]  RCU_STATE,      // reconfig states
  input  wire  logic [console_pkg::N_RCU-1:0]    RCU_TEST,       // reconfig test
  input  wire  logic [console_pkg::N_CE-1:0]     CE_STOPPED,     // unit stopped
  input  wire  logic [console_pkg::N_CE-1:0]     CE_WAIT,        // wait bit
  input  wire  logic [2*console_pkg::N_CE-1:0]   CE_STATE,       // unit states
  input  wire  logic [console_pkg::N_CE-1:0]     CE_TEST,        // unit test sw
  input  wire  logic [3*console_pkg::IC_W-1:0]   CE_IC,          // counters
  input  wire  logic                             SD_VALID,       // display data
  input  wire  logic [console_pkg::SD_W-1:0]     SD_IN,          // storage word
  input  wire  logic [1:0]                       CU_DISC_DONE,   // disconnected
  input  wire  logic                             SENSE_CMD,      // read-sense cmd
  output logic [console_pkg::N_CE-1:0]           CE_SELECT,      // one-hot select
  output logic                                   REQ_START,      // start pulse
  output logic                                   REQ_STOP,       // stop pulse
  output logic                                   REQ_ALLSTOP,    // all-stop pulse
  output logic                                   REQ_SETIC,      // set counter
  output logic                                   REQ_STORE,      // store pulse
  output logic                                   REQ_DISPLAY,    // display pulse
  output logic                                   REQ_INTR,       // interrupt
  output logic                                   REQ_LOAD,       // load pulse
  output logic                                   LOAD_SYSTEM,    // system load
  output logic                                   REQ_ACTIVATE,   // activate pulse
  output logic                                   ACMP_EN,        // compare enable
  output logic [26:0]                            ADDR_OUT,       // addr + parity
  output logic [35:0]                            DATA_OUT,       // data + parity
  output logic [3:0]                             LOAD_MS,        // storage + par
  output logic [4:0]                             LOAD_CHAN,      // channel + par
  output logic [8:0]                             LOAD_UNIT,      // unit + par
  output logic [6:0]                             SENSE_OUT,      // sense + par
  output logic                                   SENSE_VALID,    // sense pulse
  output logic [console_pkg::N_RCU-1:0]          RCU_PWR_EN,     // reconfig power
  output logic [console_pkg::N_RCU-1:0]          RCU_IF_EN,      // reconfig iface
  output logic [console_pkg::N_CE-1:0]           MANUAL_LAMP,    // stopped lamps
  output logic [console_pkg::N_CE-1:0]           WAIT_LAMP,      // wait lamps
  output logic [3*console_pkg::IC_W-1:0]         IA_LAMPS,       // counter lamps
  output logic [console_pkg::SD_W-1:0]           SD_LAMPS,       // data lamps
  output logic [4*console_pkg::N_DISP-1:0]       DISP_LAMPS,     // unit status
  output logic [95:0]                            CFG_LAMPS,      // config lamps
  output logic                                   ILK_LAMP,       // interlock lamp
  output logic                                   DISABLED_LAMP   // disabled lamp
);
  import console_pkg::*;

  typedef struct packed {
    logic [PANEL_W-1:0]  s1;
    logic [PANEL_W-1:0]  s2;
    logic [N_BTN-1:0]    prev;
    logic [N_BTN-1:0]    req;
    logic                load_sys;
    logic                acen;
    logic [1:0]          sel;
    logic [N_CE-1:0]     cesel;
    logic [26:0]         addr;
    logic [35:0]         data;
    logic [3:0]          ms;
    logic [4:0]          chan;
    logic [8:0]          unit;
    logic [6:0]          sense;
    logic                sense_vld;
    logic [N_RCU-1:0]    rpwr;
    logic [N_RCU-1:0]    rif;
    logic [N_CE-1:0]     manual;
    logic [N_CE-1:0]     waitl;
    logic [3*IC_W-1:0]   ia;
    logic [SD_W-1:0]     sd;
    logic [63:0]         disp;
    logic [95:0]         cfg;
    logic                ilk_lamp;
    logic                disabled;
    logic                aw_ok;
    logic [AXI_AW-1:0]   aw_addr;
    logic                w_ok;
    logic [31:0]         wd;
    logic [3:0]          ws;
    logic                awready;
    logic                wready;
    logic                bvalid;
    logic [1:0]          bresp;
    logic                arready;
    logic                rvalid;
    logic [31:0]         rdata;
    logic [1:0]          rresp;
  } state_type;

  state_type           r;
  state_type           next_r;
  logic [PANEL_W-1:0]  pins;
  logic [N_BTN-1:0]    press;
  logic [N_BTN-1:0]    go;
  logic                ilk;
  logic                sel_ok;
  logic                sel_stopped;
  logic                subsys_ok;
  logic [1:0]          sel_state;
  logic [31:0]         rd;
  logic                rd_hit;
  logic [35:0]         addr_par;

  assign pins = {RCU_IF_SW, RCU_PWR_SW, SENSE_SW, ADDR_KEYS, DATA_KEYS, UNIT_SW,
                 CHAN_SW, MS_SEL_SW, CE_SEL_SW, DISABLE_SW, KEY_ILK, PB};

  always_comb begin
    next_r = r;
    next_r.s1 = pins;
    next_r.s2 = r.s1;
    ilk = r.s2[P_ILK];
    press = r.s2[N_BTN-1:0] & ~r.prev;
    go = press & {N_BTN{ilk}};
    next_r.prev = r.s2[N_BTN-1:0];
    sel_ok = (r.sel < 2'(N_CE));
    sel_stopped = sel_ok && CE_STOPPED[r.sel];
    sel_state = sel_ok ? CE_STATE[2*r.sel+:2] : 2'h3;
    subsys_ok = sel_ok && ((sel_state == ST_ONE) || (sel_state == ST_ZERO && !CE_TEST[r.sel]));
    if (ilk) begin
      next_r.sel = r.s2[P_CESEL+:2];
    end
    // select lamps registered so the output comes from a flip-flop
    next_r.cesel = (next_r.sel < 2'(N_CE)) ? N_CE'(3'h1 << next_r.sel) : '0;
    next_r.req = '0;
    next_r.req[B_START] = go[B_START];
    next_r.req[B_STOP] = go[B_STOP];
    next_r.req[B_ALLSTOP] = go[B_ALLSTOP];
    next_r.req[B_INTR] = go[B_INTR];
    next_r.req[B_ACT] = go[B_ACT];
    next_r.req[B_SETIC] = go[B_SETIC] & sel_stopped;
    next_r.req[B_STORE] = go[B_STORE] & sel_stopped;
    next_r.req[B_DISPLAY] = go[B_DISPLAY] & sel_stopped;
    next_r.req[B_LOAD] = go[B_LOAD] & (r.s2[B_SYSIPL] | subsys_ok);
    next_r.load_sys = r.s2[B_SYSIPL];
    next_r.acen = ilk & r.s2[B_ACEN];
    // key and load switch payloads stand every cycle so they are valid with each pulse; sense is captured only on SENSE_CMD
    addr_par = byte_par({8'h00, r.s2[P_ADDR+:24]});
    next_r.addr = addr_par[26:0];
    next_r.data = byte_par(r.s2[P_DATA+:32]);
    next_r.ms = {odd_par8({5'h00, r.s2[P_MS+:3]}), r.s2[P_MS+:3]};
    next_r.chan = {odd_par8({4'h0, r.s2[P_CHAN+:4]}), r.s2[P_CHAN+:4]};
    next_r.unit = {odd_par8(r.s2[P_UNIT+:8]), r.s2[P_UNIT+:8]};
    next_r.sense_vld = SENSE_CMD;
    if (SENSE_CMD) begin
      next_r.sense = {odd_par8({2'h0, r.s2[P_SENSE+:6]}), r.s2[P_SENSE+:6]};
    end
    for (int i = 0; i < N_RCU; i++) begin
      if (RCU_STATE[2*i+:2] == ST_ZERO && RCU_TEST[i]) begin
        next_r.rpwr[i] = r.s2[P_RPWR+i];
        next_r.rif[i] = r.s2[P_RIF+i];
      end
    end
    next_r.manual = CE_STOPPED;
    next_r.waitl = CE_WAIT;
    next_r.ia = CE_IC;
    if (SD_VALID) begin
      next_r.sd = SD_IN;
    end
    next_r.ilk_lamp = ilk;
    next_r.disabled = r.s2[P_DIS] & (&CU_DISC_DONE);
    // register bus write side
    if (AWVALID && r.awready) begin
      next_r.aw_ok = 1'b1;
      next_r.aw_addr = AWADDR;
    end
    if (WVALID && r.wready) begin
      next_r.w_ok = 1'b1;
      next_r.wd = WDATA;
      next_r.ws = WSTRB;
    end
    if (r.bvalid && BREADY) begin
      next_r.bvalid = 1'b0;
    end
    if (r.aw_ok && r.w_ok && !r.bvalid) begin
      next_r.aw_ok = 1'b0;
      next_r.w_ok = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp = RESP_OKAY;
      case (r.aw_addr)
        OFS_DISP_LO: next_r.disp[31:0] = wmerge(r.disp[31:0], r.wd, r.ws);
        OFS_DISP_HI: next_r.disp[63:32] = wmerge(r.disp[63:32], r.wd, r.ws) & 32'h0fffffff;
        OFS_CFG1: next_r.cfg[31:0] = wmerge(r.cfg[31:0], r.wd, r.ws);
        OFS_CFG2: next_r.cfg[63:32] = wmerge(r.cfg[63:32], r.wd, r.ws);
        OFS_CFG3: next_r.cfg[95:64] = wmerge(r.cfg[95:64], r.wd, r.ws);
        OFS_STATUS, OFS_SD_LO, OFS_SD_HI: next_r.bresp = RESP_OKAY;
        default: next_r.bresp = RESP_SLVERR;
      endcase
    end
    if (press[B_RESET]) begin
      next_r.cfg = '0;
      next_r.sd = '0;
    end
    next_r.awready = !next_r.aw_ok && !next_r.bvalid;
    next_r.wready = !next_r.w_ok && !next_r.bvalid;
    // register bus read side
    rd_hit = 1'b1;
    case (ARADDR)
      OFS_DISP_LO: rd = r.disp[31:0];
      OFS_DISP_HI: rd = r.disp[63:32];
      OFS_CFG1: rd = r.cfg[31:0];
      OFS_CFG2: rd = r.cfg[63:32];
      OFS_CFG3: rd = r.cfg[95:64];
      OFS_STATUS: rd = {22'h0, r.sel, r.disabled, r.ilk_lamp, r.waitl, r.manual};
      OFS_SD_LO: rd = r.sd[31:0];
      OFS_SD_HI: rd = {28'h0, r.sd[35:32]};
      default: begin
        rd = RST_WORD;
        rd_hit = 1'b0;
      end
    endcase
    if (ARVALID && r.arready) begin
      next_r.rvalid = 1'b1;
      next_r.rdata = rd;
      next_r.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (r.rvalid && RREADY) begin
      next_r.rvalid = 1'b0;
    end
    next_r.arready = !next_r.rvalid;
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign AWREADY       = r.awready;
  assign WREADY        = r.wready;
  assign BVALID        = r.bvalid;
  assign BRESP         = r.bresp;
  assign ARREADY       = r.arready;
  assign RVALID        = r.rvalid;
  assign RDATA         = r.rdata;
  assign RRESP         = r.rresp;
  assign CE_SELECT     = r.cesel;
  assign REQ_START     = r.req[B_START];
  assign REQ_STOP      = r.req[B_STOP];
  assign REQ_ALLSTOP   = r.req[B_ALLSTOP];
  assign REQ_SETIC     = r.req[B_SETIC];
  assign REQ_STORE     = r.req[B_STORE];
  assign REQ_DISPLAY   = r.req[B_DISPLAY];
  assign REQ_INTR      = r.req[B_INTR];
  assign REQ_LOAD      = r.req[B_LOAD];
  assign LOAD_SYSTEM   = r.load_sys;
  assign REQ_ACTIVATE  = r.req[B_ACT];
  assign ACMP_EN       = r.acen;
  assign ADDR_OUT      = r.addr;
  assign DATA_OUT      = r.data;
  assign LOAD_MS       = r.ms;
  assign LOAD_CHAN     = r.chan;
  assign LOAD_UNIT     = r.unit;
  assign SENSE_OUT     = r.sense;
  assign SENSE_VALID   = r.sense_vld;
  assign RCU_PWR_EN    = r.rpwr;
  assign RCU_IF_EN     = r.rif;
  assign MANUAL_LAMP   = r.manual;
  assign WAIT_LAMP     = r.waitl;
  assign IA_LAMPS      = r.ia;
  assign SD_LAMPS      = r.sd;
  assign DISP_LAMPS    = r.disp[4*N_DISP-1:0];
  assign CFG_LAMPS     = r.cfg;
  assign ILK_LAMP      = r.ilk_lamp;
  assign DISABLED_LAMP = r.disabled;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);

  sequence s_reset_press;
    !r.s2[B_RESET] ##1 r.s2[B_RESET];
  endsequence
  sequence s_sense_cmd;
    SENSE_CMD;
  endsequence
  sequence s_rcu0_locked;
    !(RCU_STATE[1:0] == ST_ZERO && RCU_TEST[0]);
  endsequence

  AST_ILK_GATE: assert property ((REQ_STORE || REQ_LOAD || REQ_INTR || REQ_STOP) |-> $past(r.s2[P_ILK]))
    else $error("manual request without interlock");
  AST_PULSE_ONE: assert property (REQ_STOP |=> !REQ_STOP)
    else $error("stop request longer than one cycle");
  AST_STORE_STOPPED: assert property ((REQ_STORE || REQ_SETIC || REQ_DISPLAY) |-> $past(sel_stopped))
    else $error("store or display while unit running");
  AST_SUBSYS_LOAD: assert property ((REQ_LOAD && !LOAD_SYSTEM) |-> $past(subsys_ok))
    else $error("subsystem load in wrong state");
  AST_LOAD_PAR: assert property (!SRST |=> (^LOAD_MS) && (^LOAD_CHAN) && (^LOAD_UNIT))
    else $error("load switch parity not odd");
  AST_DATA_PAR: assert property (!SRST |=> (^DATA_OUT[35:27]) && (^DATA_OUT[8:0]) && (^ADDR_OUT[26:18]))
    else $error("key byte parity not odd");
  AST_CFG_RESET: assert property (s_reset_press |=> (CFG_LAMPS == '0))
    else $error("console reset left configuration lamps");
  AST_SENSE: assert property (s_sense_cmd |=> SENSE_VALID && (^SENSE_OUT) && SENSE_OUT[5:0] == $past(r.s2[P_SENSE+:6]))
    else $error("sense return wrong");
  AST_DISABLED: assert property (DISABLED_LAMP |-> $past(r.s2[P_DIS] && (&CU_DISC_DONE)))
    else $error("disabled lamp early");
  AST_MANUAL: assert property (##1 MANUAL_LAMP == $past(CE_STOPPED) && WAIT_LAMP == $past(CE_WAIT))
    else $error("status lamps not mirroring");
  AST_RCU_HOLD: assert property (s_rcu0_locked |=> $stable({RCU_PWR_EN[0], RCU_IF_EN[0]}))
    else $error("reconfig switch acted outside state zero test");
  AST_ACMP_ILK: assert property (ACMP_EN |-> $past(r.s2[P_ILK]))
    else $error("compare enable without interlock");
endmodule
`default_nettype wire

// File: inc/console_pkg.sv
// Notes on behaviour
// - four program-set status lamps per display generator and radar keyboard mux
// - three configuration lamp registers, held until rewritten or console reset
// - storage data lamps show 36 bits, no parity check here
// - each compute unit instruction counter shown on 27 lamps, unchecked
// - manual lamp mirrors stopped state, wait lamp mirrors wait bit
// - disabled lamp on only when switch set and both control units disconnected
// - manual controls act only with interlock key on; reset and sense always
// - reconfig unit power and interface switches act only in state zero with test
// - storage select sent binary with odd parity, room for eight units
// - channel address 0 to A sent binary with odd parity
// - two unit-address digits form 8 bits under one odd parity bit
// - load with system button held is system load, else subsystem if allowed
// - load presents switch settings to selected unit; unit drives load lamp
// - 32 data keys and 24 address keys get odd parity per byte
// - six sense switches returned with odd parity on read-sense command
// - interrupt button sends console interrupt to selected unit
// - set counter loads address keys with parity when unit stopped
// - store writes data keys to keyed address when unit stopped
// - display reads keyed word into storage data lamps when unit stopped
package console_pkg;
  localparam int AXI_AW = 8;
  localparam logic [7:0] OFS_DISP_LO = 8'h00;
  localparam logic [7:0] OFS_DISP_HI = 8'h04;
  localparam logic [7:0] OFS_CFG1    = 8'h08;
  localparam logic [7:0] OFS_CFG2    = 8'h0c;
  localparam logic [7:0] OFS_CFG3    = 8'h10;
  localparam logic [7:0] OFS_STATUS  = 8'h14;
  localparam logic [7:0] OFS_SD_LO   = 8'h18;
  localparam logic [7:0] OFS_SD_HI   = 8'h1c;
  localparam logic [31:0] RST_WORD   = 32'h0;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int N_CE   = 3;
  localparam int IC_W   = 27;
  localparam int SD_W   = 36;
  localparam int N_DISP = 15;
  localparam int N_RCU  = 2;
  localparam logic [1:0] ST_ZERO = 2'h0;
  localparam logic [1:0] ST_ONE  = 2'h1;
  localparam int B_START   = 0;
  localparam int B_STOP    = 1;
  localparam int B_ALLSTOP = 2;
  localparam int B_SETIC   = 3;
  localparam int B_STORE   = 4;
  localparam int B_DISPLAY = 5;
  localparam int B_INTR    = 6;
  localparam int B_LOAD    = 7;
  localparam int B_SYSIPL  = 8;
  localparam int B_ACT     = 9;
  localparam int B_ACEN    = 10;
  localparam int B_RESET   = 11;
  localparam int N_BTN     = 12;
  localparam int P_ILK     = 12;
  localparam int P_DIS     = 13;
  localparam int P_CESEL   = 14;
  localparam int P_MS      = 16;
  localparam int P_CHAN    = 19;
  localparam int P_UNIT    = 23;
  localparam int P_DATA    = 31;
  localparam int P_ADDR    = 63;
  localparam int P_SENSE   = 87;
  localparam int P_RPWR    = 93;
  localparam int P_RIF     = 95;
  localparam int PANEL_W   = 97;

  function automatic logic odd_par8(input logic [7:0] v);
    return ~(^v);
  endfunction

  function automatic logic [35:0] byte_par(input logic [31:0] d);
    return {odd_par8(d[31:24]), d[31:24], odd_par8(d[23:16]), d[23:16],
            odd_par8(d[15:8]), d[15:8], odd_par8(d[7:0]), d[7:0]};
  endfunction

  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] s);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) m[8*i+:8] = d[8*i+:8];
    end
    return m;
  endfunction
endpackage

// File: test/ce_model.sv
`timescale 1ns/10ps
`default_nettype none
module ce_model (
  input  wire logic        CLK,          // clock
  input  wire logic        SRST,         // sync reset
  input  wire logic        REQ_STORE,    // store pulse
  input  wire logic        REQ_DISPLAY,  // display pulse
  input  wire logic [35:0] DATA_OUT,     // data + parity
  input  wire logic [26:0] ADDR_OUT,     // addr + parity
  output logic             SD_VALID,     // word valid
  output logic [35:0]      SD_IN,        // storage word
  output logic             PAR_BAD,      // even parity seen
  output logic             INVALID_SEL   // bad address seen
);
  logic [35:0] mem;
  always_ff @(posedge CLK) begin
    if (SRST) begin
      SD_VALID <= 1'b0;
      SD_IN    <= 36'h0;
      PAR_BAD  <= 1'b0;
      mem      <= 36'h0;
      INVALID_SEL <= 1'b0;
    end else begin
      SD_VALID <= REQ_DISPLAY;
      // released bus toggles so a stale word never matches
      SD_IN    <= REQ_DISPLAY ? mem : ~SD_IN;
      // model storage spans the low 64k words only
      if (REQ_STORE || REQ_DISPLAY) INVALID_SEL <= (ADDR_OUT[25:18] != 8'h00);
      if (REQ_STORE) begin
        mem <= DATA_OUT;
        for (int i = 0; i < 4; i++) begin
          if (~^DATA_OUT[9*i+:9]) PAR_BAD <= 1'b1;
        end
        for (int i = 0; i < 3; i++) begin
          if (~^ADDR_OUT[9*i+:9]) PAR_BAD <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: test/operator_console_manual_control_bench.sv
`timescale 1ns/10ps
`default_nettype none
module operator_console_manual_control_bench;
  import console_pkg::*;
  logic        CLK, SRST, AWVALID, WVALID, BREADY, ARVALID, RREADY, KEY_ILK, DISABLE_SW, SD_VALID, SENSE_CMD;
  logic        AWREADY, WREADY, BVALID, ARREADY, RVALID, REQ_START, REQ_STOP, REQ_ALLSTOP, REQ_SETIC;
  logic        REQ_STORE, REQ_DISPLAY, REQ_INTR, REQ_LOAD, LOAD_SYSTEM, REQ_ACTIVATE, ACMP_EN, SENSE_VALID;
  logic        ILK_LAMP, DISABLED_LAMP, PAR_BAD, INVALID_SEL;
  logic [1:0]  BRESP, RRESP, CE_SEL_SW, RCU_PWR_SW, RCU_IF_SW, RCU_TEST, CU_DISC_DONE, RCU_PWR_EN, RCU_IF_EN;
  logic [2:0]  MS_SEL_SW, CE_STOPPED, CE_WAIT, CE_TEST, CE_SELECT, MANUAL_LAMP, WAIT_LAMP;
  logic [3:0]  WSTRB, CHAN_SW, RCU_STATE, LOAD_MS;
  logic [4:0]  LOAD_CHAN;
  logic [5:0]  SENSE_SW, CE_STATE;
  logic [6:0]  SENSE_OUT;
  logic [7:0]  AWADDR, ARADDR, UNIT_SW;
  logic [8:0]  LOAD_UNIT, rq;
  logic [11:0] PB;
  logic [23:0] ADDR_KEYS;
  logic [26:0] ADDR_OUT;
  logic [31:0] WDATA, RDATA, DATA_KEYS, d;
  logic [35:0] SD_IN, DATA_OUT, SD_LAMPS, e;
  logic [59:0] DISP_LAMPS;
  logic [80:0] CE_IC, IA_LAMPS;
  logic [95:0] CFG_LAMPS;
  logic [1:0]  r;
  logic [31:0] v [5];
  logic [7:0]  ofs [5] = '{OFS_DISP_LO, OFS_DISP_HI, OFS_CFG1, OFS_CFG2, OFS_CFG3};
  logic [7:0]  pc [9] = '{default: 8'h00};
  int          error_cnt = 0;
  int          n_tests = 0;

  console_ctrl u_console_ctrl (.*);
  ce_model u_ce_model (.*);

  assign rq = {REQ_ACTIVATE, REQ_LOAD, REQ_INTR, REQ_DISPLAY, REQ_STORE, REQ_SETIC, REQ_ALLSTOP, REQ_STOP, REQ_START};
  always @(posedge CLK) begin
    for (int i = 0; i < 9; i++) begin
      if (!SRST) pc[i] <= pc[i] + 8'(rq[i]);
    end
  end
  always #4 CLK = ~CLK;

  function automatic logic [35:0] bp(input logic [31:0] x);
    logic [35:0] o;
    for (int i = 0; i < 4; i++) o[9*i+:9] = {~^x[8*i+:8], x[8*i+:8]};
    return o;
  endfunction

  task chk(input string n, input logic [95:0] ex, input logic [95:0] g);
    n_tests++;
    if (g !== ex) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, ex, g);
    end
  endtask

  task complete_run;
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] x, output logic [1:0] rs);
    logic ta, tw, t;
    ta = 1'b0;
    tw = 1'b0;
    @(posedge CLK);
    AWADDR <= a; WDATA <= x; WSTRB <= 4'hf; AWVALID <= 1'b1; WVALID <= 1'b1; BREADY <= 1'b1;
    do begin
      @(negedge CLK);
      ta = ta | AWREADY;
      tw = tw | WREADY;
      @(posedge CLK);
      if (ta) AWVALID <= 1'b0;
      if (tw) WVALID <= 1'b0;
    end while (!(ta && tw));
    do begin
      @(negedge CLK);
      t = BVALID;
      rs = BRESP;
      @(posedge CLK);
    end while (!t);
    BREADY <= 1'b0;
  endtask

  task rd(input logic [7:0] a, output logic [31:0] x, output logic [1:0] rs);
    logic t;
    @(posedge CLK);
    ARADDR <= a; ARVALID <= 1'b1; RREADY <= 1'b1;
    do begin
      @(negedge CLK);
      t = ARREADY;
      @(posedge CLK);
    end while (!t);
    ARVALID <= 1'b0;
    do begin
      @(negedge CLK);
      t = RVALID;
      x = RDATA;
      rs = RRESP;
      @(posedge CLK);
    end while (!t);
    RREADY <= 1'b0;
  endtask

  task press(input int b);
    @(posedge CLK) PB[b] <= 1'b1;
    repeat (3) @(posedge CLK);
    PB[b] <= 1'b0;
    repeat (6) @(posedge CLK);
  endtask

  initial begin
    #100000;
    error_cnt++;
    complete_run;
  end

  initial begin
    CLK = 0; SRST = 1; AWVALID = 0; WVALID = 0; BREADY = 0; ARVALID = 0; RREADY = 0; AWADDR = 0; ARADDR = 0;
    WDATA = 0; WSTRB = 0; PB = 0; KEY_ILK = 0; DISABLE_SW = 0; CE_SEL_SW = 0; MS_SEL_SW = 0; CHAN_SW = 0;
    UNIT_SW = 0; DATA_KEYS = 0; ADDR_KEYS = 0; SENSE_SW = 0; RCU_PWR_SW = 0; RCU_IF_SW = 0; RCU_STATE = 0;
    RCU_TEST = 0; CE_STOPPED = 0; CE_WAIT = 0; CE_STATE = 0; CE_TEST = 0; CE_IC = 0; CU_DISC_DONE = 0;
    SENSE_CMD = 0;
    void'($urandom(32'h8d73));
    repeat (5) @(posedge CLK);
    SRST <= 1'b0;
    rd(OFS_CFG1, d, r);
    chk("cfg1 reset", RST_WORD, d);
    rd(8'h40, d, r);
    chk("unmapped resp", RESP_SLVERR, r);
    for (int k = 0; k < 5; k++) begin
      v[k] = $urandom;
      wr(ofs[k], v[k], r);
      chk("write resp", RESP_OKAY, r);
      rd(ofs[k], d, r);
      chk("readback", (k == 1) ? (v[k] & 32'h0fffffff) : v[k], d);
    end
    chk("cfg lamps", {v[4], v[3], v[2]}, CFG_LAMPS);
    chk("disp lamps", {v[1][27:0], v[0]}, DISP_LAMPS);
    @(posedge CLK);
    DATA_KEYS <= $urandom; ADDR_KEYS <= 24'($urandom); MS_SEL_SW <= 3'($urandom); UNIT_SW <= 8'($urandom);
    CHAN_SW <= 4'($urandom % 11); SENSE_SW <= 6'($urandom); CE_IC <= 81'({$urandom, $urandom, $urandom});
    CE_STOPPED <= 3'($urandom | 1); CE_WAIT <= 3'($urandom); CE_STATE <= {4'($urandom), ST_ONE};
    RCU_TEST <= 2'b01; RCU_PWR_SW <= 2'($urandom); RCU_IF_SW <= 2'($urandom);
    repeat (5) @(posedge CLK);
    @(negedge CLK);
    chk("data out", bp(DATA_KEYS), DATA_OUT);
    e = bp({8'h00, ADDR_KEYS});
    chk("addr out", e[26:0], ADDR_OUT);
    chk("storage sel", {~^MS_SEL_SW, MS_SEL_SW}, LOAD_MS);
    chk("channel", {~^CHAN_SW, CHAN_SW}, LOAD_CHAN);
    chk("unit addr", {~^UNIT_SW, UNIT_SW}, LOAD_UNIT);
    chk("manual lamps", CE_STOPPED, MANUAL_LAMP);
    chk("wait lamps", CE_WAIT, WAIT_LAMP);
    chk("ia lamps", CE_IC, IA_LAMPS);
    chk("rcu power", {1'b0, RCU_PWR_SW[0]}, RCU_PWR_EN);
    chk("rcu iface", {1'b0, RCU_IF_SW[0]}, RCU_IF_EN);
    // first pass interlock off, second on: one pulse each overall
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 9; i++) press(i < 8 ? i : 9);
      KEY_ILK <= 1'b1;
    end
    @(negedge CLK);
    for (int i = 0; i < 9; i++) chk("pulse count", 1, pc[i]);
    chk("select", 3'b001, CE_SELECT);
    chk("interlock lamp", 1, ILK_LAMP);
    chk("sd lamps", bp(DATA_KEYS), SD_LAMPS);
    chk("parity", 0, PAR_BAD);
    chk("invalid sel", ADDR_KEYS[23:16] != 8'h00, INVALID_SEL);
    // unit in state three: subsystem load refused, system load taken
    @(posedge CLK) CE_STATE <= 6'h3f;
    press(B_LOAD);
    PB[B_SYSIPL] <= 1'b1;
    PB[B_ACEN] <= 1'b1;
    press(B_LOAD);
    @(negedge CLK);
    chk("load count", 2, pc[B_LOAD]);
    chk("system load", 1, LOAD_SYSTEM);
    chk("compare enable", 1, ACMP_EN);
    @(posedge CLK) PB <= '0;
    @(posedge CLK) SENSE_CMD <= 1'b1;
    @(posedge CLK) SENSE_CMD <= 1'b0;
    @(negedge CLK) chk("sense valid", 1, SENSE_VALID);
    repeat (2) @(posedge CLK);
    @(negedge CLK);
    chk("sense", {~^SENSE_SW, SENSE_SW}, SENSE_OUT);
    @(posedge CLK);
    DISABLE_SW <= 1'b1;
    CU_DISC_DONE <= 2'b01;
    repeat (5) @(posedge CLK);
    @(negedge CLK);
    chk("disabled early", 0, DISABLED_LAMP);
    @(posedge CLK) CU_DISC_DONE <= 2'b11;
    repeat (5) @(posedge CLK);
    @(negedge CLK);
    chk("disabled", 1, DISABLED_LAMP);
    @(posedge CLK) KEY_ILK <= 1'b0;
    press(B_RESET);
    @(negedge CLK);
    chk("cfg cleared", 0, CFG_LAMPS);
    chk("sd cleared", 0, SD_LAMPS);
    chk("disp kept", {v[1][27:0], v[0]}, DISP_LAMPS);
    rd(OFS_STATUS, d, r);
    chk("status", {22'h0, 2'b00, 1'b1, 1'b0, CE_WAIT, CE_STOPPED}, d);
    complete_run;
  end
endmodule
`default_nettype wire
